// [logic/scr_pkg.sv]
// constants for the converter control and status register block
package scr_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] STAT_OFS      = 12'h004;
	localparam logic [11:0] BASE_OFS      = 12'h008;
	localparam logic [11:0] PCFG_OFS      = 12'h00c;
	localparam logic [11:0] TRIG_OFS      = 12'h010;

	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int MODULE_ON_BIT   = 15;
	localparam int IDLE_STOP_BIT   = 13;
	localparam int GLOBAL_TRIG_BIT = 10;
	localparam int FORMAT_BIT      = 8;
	localparam int EARLY_INT_BIT   = 7;
	localparam int ORDER_BIT       = 6;
	localparam int SEQ_SAMP_BIT    = 5;
	localparam int CLK_SEL_LSB     = 0;

	// writable bits of the control, base and pin configuration registers
	localparam logic [15:0] CTRL_MASK     = 16'ha5e7;
	localparam logic [15:0] BASE_MASK     = 16'hfffe;
	localparam logic [15:0] PCFG_MASK     = 16'h0fff;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] CTRL_RST      = 16'h0003;
	localparam logic [15:0] BASE_RST      = 16'h0000;
	localparam logic [11:0] PCFG_RST      = 12'h000;
	localparam logic [4:0]  TRIG_RST      = 5'h00;

	// ----------------------------------------
	// sizes and codes
	// ----------------------------------------
	localparam int NUM_PAIRS     = 6;
	localparam int NUM_PINS      = 12;
	localparam int RES_BITS      = 10;
	localparam int TRIG_BITS     = 5;
	localparam logic [4:0] TRIG_OFF    = 5'h00;
	localparam logic [4:0] TRIG_GLOBAL = 5'h02;

	// system clock period in ns (base time unit of the divider)
	localparam int SYS_CLK_NS    = 100;

	// conversion sequencer states
	typedef enum logic [1:0] {
		SCR_IDLE,
		SCR_FIRST,
		SCR_SECOND
	} scr_state_e;

endpackage

// [logic/scr_top.sv]
// converter control, status, vector base and pin configuration registers
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
module scr_top (
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [11:0]                           paddr,
	input  wire logic [31:0]                           pwdata,
	output logic                                       pready,
	output logic      [31:0]                           prdata,
	output logic                                       pslverr,
	input  wire logic                                  device_idle,
	input  wire logic [scr_pkg::NUM_PAIRS-1:0]         pair_trigger,
	input  wire logic [scr_pkg::RES_BITS-1:0]          conv_result,
	output logic                                       conv_clk_tick,
	output logic                                       conv_busy,
	output logic                                       conv_odd_input,
	output logic      [2:0]                            conv_pair,
	output logic                                       shared_sample,
	output logic                                       dedicated_sample,
	output logic      [15:0]                           result_data,
	output logic                                       result_valid,
	output logic      [scr_pkg::NUM_PAIRS-1:0]         pair_irq,
	output logic      [scr_pkg::NUM_PINS-1:0]          pin_digital,
	output logic      [scr_pkg::NUM_PINS-1:0]          mux_to_ground
);
	import scr_pkg::*;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// lowest numbered set flag wins
	function automatic logic [2:0] enc_ready(input logic [NUM_PAIRS-1:0] f);
		logic [2:0] n;
		n = 3'd0;
		for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
			if (f[i]) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [15:0]            ctrl_ff;
	logic [15:0]            base_ff;
	logic [NUM_PINS-1:0]    pcfg_ff;
	logic [NUM_PAIRS-1:0]   ready_ff;
	logic [NUM_PAIRS-1:0]   pend_ff;
	logic [TRIG_BITS-1:0]   trig_src_ff [NUM_PAIRS];
	logic                   gtrig_prev_ff;
	logic [2:0]             div_ff;
	scr_state_e             state_ff;
	logic [2:0]             pair_ff;
	logic [15:0]            result_ff;
	logic                   result_valid_ff;
	logic [NUM_PAIRS-1:0]   irq_ff;
	logic                   shared_ff;
	logic                   dedicated_ff;

	logic                   wr_en;
	logic                   rd_en;
	logic                   hit;
	logic                   running;
	logic                   tick;
	logic                   gtrig_rise;
	logic [NUM_PAIRS-1:0]   req;
	logic [NUM_PAIRS-1:0]   set_ready;
	logic [15:0]            base_rd;
	logic [15:0]            fmt;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// address decode; the trigger block spans one word per pair
	always_comb begin
		hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == BASE_OFS) ||
			(paddr == PCFG_OFS) ||
			((paddr >= TRIG_OFS) && (paddr < TRIG_OFS + 12'(4 * NUM_PAIRS)) &&
			(paddr[1:0] == 2'b00));
	end

	// ----------------------------------------
	// software writable registers
	// ----------------------------------------
	// order and early bits only move while converter is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_en && paddr == CTRL_OFS) begin
			ctrl_ff <= pwdata[15:0] & CTRL_MASK;
			if (ctrl_ff[MODULE_ON_BIT]) begin
				ctrl_ff[EARLY_INT_BIT] <= ctrl_ff[EARLY_INT_BIT];
				ctrl_ff[ORDER_BIT]     <= ctrl_ff[ORDER_BIT];
			end
		end
	end

	// base and pin configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_ff <= BASE_RST;
			pcfg_ff <= PCFG_RST;
		end else if (wr_en) begin
			if (paddr == BASE_OFS) begin
				base_ff <= pwdata[15:0] & BASE_MASK;
			end
			if (paddr == PCFG_OFS) begin
				pcfg_ff <= pwdata[NUM_PINS-1:0];
			end
		end
	end

	// per-pair trigger source words
	for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_trig
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				trig_src_ff[g] <= TRIG_RST;
			end else if (wr_en && paddr == TRIG_OFS + 12'(4 * g)) begin
				trig_src_ff[g] <= pwdata[TRIG_BITS-1:0];
			end
		end
	end

	// ----------------------------------------
	// ready flags
	// ----------------------------------------
	// write 0 clears, write 1 keeps; a hardware set wins the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_ff <= '0;
		end else if (wr_en && paddr == STAT_OFS) begin
			ready_ff <= (ready_ff & pwdata[NUM_PAIRS-1:0]) | set_ready;
		end else begin
			ready_ff <= ready_ff | set_ready;
		end
	end

	// ----------------------------------------
	// triggers and pending requests
	// ----------------------------------------
	// level bit: only a 0 to 1 change counts, so software must clear it first
	assign gtrig_rise = ctrl_ff[GLOBAL_TRIG_BIT] & ~gtrig_prev_ff;
	assign running    = ctrl_ff[MODULE_ON_BIT] &
		~(ctrl_ff[IDLE_STOP_BIT] & device_idle);

	always_comb begin
		for (int i = 0; i < NUM_PAIRS; i++) begin
			if (trig_src_ff[i] == TRIG_GLOBAL) begin
				req[i] = gtrig_rise;
			end else if (trig_src_ff[i] == TRIG_OFF) begin
				req[i] = 1'b0;
			end else begin
				req[i] = pair_trigger[i];
			end
		end
	end

	// pending set by a request, dropped when sequencer takes the pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gtrig_prev_ff <= 1'b0;
			pend_ff       <= '0;
		end else begin
			gtrig_prev_ff <= ctrl_ff[GLOBAL_TRIG_BIT];
			if (!ctrl_ff[MODULE_ON_BIT]) begin
				pend_ff <= '0;
			end else begin
				for (int i = 0; i < NUM_PAIRS; i++) begin
					if (req[i]) begin
						pend_ff[i] <= 1'b1;
					end else if (tick && state_ff == SCR_IDLE && running &&
						pend_ff != '0 && enc_ready(pend_ff) == 3'(i)) begin
						pend_ff[i] <= 1'b0;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// conversion clock divider
	// ----------------------------------------
	// one tick every select plus one system periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 3'd0;
		end else if (!running || div_ff >= ctrl_ff[CLK_SEL_LSB+:3]) begin
			div_ff <= 3'd0;
		end else begin
			div_ff <= div_ff + 3'd1;
		end
	end
	assign tick          = running && (div_ff >= ctrl_ff[CLK_SEL_LSB+:3]);
	assign conv_clk_tick = tick;

	// ----------------------------------------
	// pair sequencer
	// ----------------------------------------
	// each busy state lasts one conversion clock; lowest pending pair first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= SCR_IDLE;
			pair_ff  <= 3'd0;
		end else if (!running) begin
			state_ff <= SCR_IDLE;
		end else if (tick) begin
			unique case (state_ff)
				SCR_IDLE: begin
					if (pend_ff != '0) begin
						pair_ff  <= enc_ready(pend_ff);
						state_ff <= SCR_FIRST;
					end
				end
				SCR_FIRST: begin
					state_ff <= SCR_SECOND;
				end
				SCR_SECOND: begin
					state_ff <= SCR_IDLE;
				end
			endcase
		end
	end

	assign conv_busy      = (state_ff != SCR_IDLE);
	assign conv_pair      = pair_ff;
	// order bit: odd first when set
	assign conv_odd_input = (state_ff == SCR_FIRST) ? ctrl_ff[ORDER_BIT] :
		~ctrl_ff[ORDER_BIT];

	// result capture in chosen format
	assign fmt = ctrl_ff[FORMAT_BIT] ? {conv_result, 6'h00} :
		{6'h00, conv_result};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff       <= 16'h0000;
			result_valid_ff <= 1'b0;
		end else begin
			result_valid_ff <= tick && conv_busy;
			if (tick && conv_busy) begin
				result_ff <= fmt;
			end
		end
	end
	assign result_data  = result_ff;
	assign result_valid = result_valid_ff;

	// ready set when a pair's data lands at end of its second conversion
	always_comb begin
		set_ready = '0;
		if (tick && state_ff == SCR_SECOND) begin
			set_ready[pair_ff] = 1'b1;
		end
	end

	// per-pair interrupt pulse after first or second conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= '0;
		end else begin
			irq_ff <= '0;
			if (tick && state_ff == (ctrl_ff[EARLY_INT_BIT] ? SCR_FIRST : SCR_SECOND)) begin
				irq_ff[pair_ff] <= 1'b1;
			end
		end
	end
	assign pair_irq = irq_ff;

	// ----------------------------------------
	// sample and hold strobes
	// ----------------------------------------
	// shared hold timing: sequential mode ties it to the odd conversion start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_ff      <= 1'b0;
			dedicated_ff   <= 1'b0;
		end else begin
			dedicated_ff <= tick && state_ff == SCR_IDLE && pend_ff != '0;
			shared_ff    <= 1'b0;
			if (ctrl_ff[SEQ_SAMP_BIT]) begin
				if (tick && ((state_ff == SCR_IDLE && pend_ff != '0 && ctrl_ff[ORDER_BIT]) ||
					(state_ff == SCR_FIRST && !ctrl_ff[ORDER_BIT]))) begin
					shared_ff <= 1'b1;
				end
			end else if (tick && state_ff == SCR_IDLE && pend_ff != '0) begin
				// shared hold is always free at a pair start, so it goes with dedicated
				shared_ff <= 1'b1;
			end
		end
	end
	assign shared_sample    = shared_ff;
	assign dedicated_sample = dedicated_ff;

	// ----------------------------------------
	// pins
	// ----------------------------------------
	assign pin_digital   = pcfg_ff;
	assign mux_to_ground = pcfg_ff;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	assign base_rd = base_ff + {11'h000, enc_ready(ready_ff), 2'b00};

	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			if (paddr == CTRL_OFS) begin
				prdata[15:0] = ctrl_ff;
			end else if (paddr == STAT_OFS) begin
				prdata[NUM_PAIRS-1:0] = ready_ff;
			end else if (paddr == BASE_OFS) begin
				prdata[15:0] = base_rd & BASE_MASK;
			end else if (paddr == PCFG_OFS) begin
				prdata[NUM_PINS-1:0] = pcfg_ff;
			end else begin
				for (int i = 0; i < NUM_PAIRS; i++) begin
					if (paddr == TRIG_OFS + 12'(4 * i)) begin
						prdata[TRIG_BITS-1:0] = trig_src_ff[i];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	off_stops_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_ff[MODULE_ON_BIT] |=> !conv_busy)
		else $error("converter busy while off");
	idle_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[IDLE_STOP_BIT] && device_idle |-> !tick)
		else $error("divider ran in idle with stop set");
	gtrig_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[GLOBAL_TRIG_BIT] && !(wr_en && paddr == CTRL_OFS)
		|=> ctrl_ff[GLOBAL_TRIG_BIT])
		else $error("global trigger cleared by hardware");
	format_left_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick && conv_busy && ctrl_ff[FORMAT_BIT] |=> result_data[5:0] == 6'h00)
		else $error("left justified low bits not zero");
	ready_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		set_ready[0] |=> ready_ff[0])
		else $error("ready set lost");
	ready_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == STAT_OFS && !pwdata[0] && !set_ready[0] |=> !ready_ff[0])
		else $error("ready flag not cleared");
	base_low_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		base_rd[1:0] == base_ff[1:0])
		else $error("encoded vector not shifted by two");
	vector_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
		ready_ff[0] |-> base_rd == base_ff)
		else $error("pair 0 not highest priority");
	// select held at 1 and running across three samples: tick, gap, tick
	div_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(tick, 2) && $past(ctrl_ff[2:0], 2) == 3'd1 && $past(ctrl_ff[2:0]) == 3'd1 &&
		ctrl_ff[2:0] == 3'd1 && $past(running) && running |-> !$past(tick) && tick)
		else $error("divider period wrong");
	pins_ground_a: assert property (@(posedge pclk) disable iff (!presetn)
		mux_to_ground == pin_digital)
		else $error("digital pin not grounded at mux");

endmodule

// [sim/scr_tb.sv]
// self-checking bench for the converter control and status register block
`timescale 1ns/10ps
module testbench;
	import scr_pkg::*;

	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, q;
	logic                 device_idle, conv_clk_tick, conv_busy, conv_odd_input;
	logic                 shared_sample, dedicated_sample, result_valid, busy_d, first_odd;
	logic [NUM_PAIRS-1:0] pair_trigger, pair_irq, irq_pair;
	logic [RES_BITS-1:0]  conv_result;
	logic [2:0]           conv_pair;
	logic [15:0]          result_data, last_data;
	logic [NUM_PINS-1:0]  pin_digital, mux_to_ground;
	int                   miscompares, check_count, res_cnt, irq_cnt, gap, last_gap, n;
	int                   cyc, ded_t, shr_lag, irq_res;

	scr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .device_idle(device_idle), .pair_trigger(pair_trigger),
		.conv_result(conv_result), .conv_clk_tick(conv_clk_tick), .conv_busy(conv_busy),
		.conv_odd_input(conv_odd_input), .conv_pair(conv_pair),
		.shared_sample(shared_sample), .dedicated_sample(dedicated_sample),
		.result_data(result_data), .result_valid(result_valid), .pair_irq(pair_irq),
		.pin_digital(pin_digital), .mux_to_ground(mux_to_ground));

	// 10 MHz system clock
	always #50 pclk = ~pclk;

	// ----------------------------------------
	// observers of the converter side
	// ----------------------------------------
	// tick spacing measured tick to tick, so it only means something while running
	always @(posedge pclk) begin
		if (result_valid === 1'b1) begin
			res_cnt <= res_cnt + 1;
			last_data <= result_data;
		end
		irq_cnt <= irq_cnt + $countones(pair_irq);
		gap <= (conv_clk_tick === 1'b1) ? 1 : gap + 1;
		if (conv_clk_tick === 1'b1) last_gap <= gap;
		busy_d <= conv_busy;
		if (conv_busy === 1'b1 && busy_d !== 1'b1) first_odd <= conv_odd_input;
		cyc <= cyc + 1;
		if (dedicated_sample === 1'b1) ded_t <= cyc;
		// shared lag counted from the last dedicated sample, zero when both fire together
		if (shared_sample === 1'b1) shr_lag <= (dedicated_sample === 1'b1) ? 0 : cyc - ded_t;
		// result count at the interrupt tells after which conversion it came
		if (|pair_irq === 1'b1) begin
			irq_res <= res_cnt;
			irq_pair <= pair_irq;
		end
	end

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// one apb transfer: setup, then access until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp, "register read");
	endtask

	// one-cycle pulse on the external trigger inputs
	task automatic pulse(input logic [NUM_PAIRS-1:0] p);
		@(posedge pclk);
		pair_trigger <= p;
		@(posedge pclk);
		pair_trigger <= '0;
	endtask

	task automatic wait_res(input int k);
		while (res_cnt < k) @(posedge pclk);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		$display("mismatch at %0t: run did not finish", $time);
		give_verdict;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
		device_idle = 0; pair_trigger = '0; conv_result = 10'h2a5;
		res_cnt = 0; irq_cnt = 0; gap = 0; last_gap = 0; busy_d = 0; first_odd = 0;
		cyc = 0; ded_t = 0; shr_lag = 0; irq_res = 0; irq_pair = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped address
		rc(CTRL_OFS, 32'h0003);
		rc(STAT_OFS, 32'h0);
		rc(BASE_OFS, 32'h0);
		rc(PCFG_OFS, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(q, 32'h0, "unmapped reads zero");
		$display("test reset values done");
		// writable masks; order and early bits frozen while module is on
		wr(CTRL_OFS, 32'hffff);
		rc(CTRL_OFS, 32'ha5e7);
		wr(CTRL_OFS, 32'h8000);
		rc(CTRL_OFS, 32'h80c0);
		wr(CTRL_OFS, 32'h0);
		rc(CTRL_OFS, 32'h00c0);
		wr(CTRL_OFS, 32'h0);
		rc(CTRL_OFS, 32'h0);
		chk(res_cnt, 0, "no pair has a source");
		wr(BASE_OFS, 32'hffff);
		rc(BASE_OFS, 32'hfffe);
		wr(STAT_OFS, 32'h3f);
		rc(STAT_OFS, 32'h0);
		wr(PCFG_OFS, 32'hffff);
		rc(PCFG_OFS, 32'h0fff);
		chk(pin_digital, 12'hfff, "digital pins");
		chk(mux_to_ground, 12'hfff, "mux grounded");
		wr(PCFG_OFS, 32'h0a5a);
		// the write lands at the edge the task returns on; look one edge later
		@(posedge pclk);
		chk(pin_digital, 12'ha5a, "analog pins");
		chk(mux_to_ground, 12'ha5a, "mux sampled");
		$display("test masks done");
		// global trigger on pairs 2 and 4, fractional, odd first, divide by 2
		wr(12'(TRIG_OFS + 8), 32'(TRIG_GLOBAL));
		wr(12'(TRIG_OFS + 16), 32'(TRIG_GLOBAL));
		wr(BASE_OFS, 32'h0100);
		wr(CTRL_OFS, 32'h0041);
		wr(CTRL_OFS, 32'h8141);
		n = res_cnt;
		wr(CTRL_OFS, 32'h8541);
		wait_res(n + 4);
		repeat (20) @(posedge pclk);
		chk(last_data, {10'h2a5, 6'h0}, "left justified");
		chk(first_odd, 1'b1, "odd input first");
		chk(last_gap, 2, "tick period");
		chk(irq_cnt, 2, "one irq per pair");
		chk(irq_res, n + 3, "irq after second conversion");
		chk(irq_pair, 6'h10, "irq of last pair");
		chk(shr_lag, 0, "shared sampled with dedicated");
		chk(conv_pair, 3'd4, "last pair converted");
		chk(conv_busy, 1'b0, "converter idle after pairs");
		rc(STAT_OFS, 32'h14);
		rc(BASE_OFS, 32'h0108);
		wr(STAT_OFS, 32'h3b);
		rc(STAT_OFS, 32'h10);
		rc(BASE_OFS, 32'h0110);
		wr(STAT_OFS, 32'h0);
		rc(BASE_OFS, 32'h0100);
		// trigger bit left at 1: rewriting it must not start again
		wr(CTRL_OFS, 32'h8541);
		repeat (40) @(posedge pclk);
		chk(res_cnt, n + 4, "no retrigger without clear");
		$display("test global trigger done");
		// integer format, even first, early irq, sequential sampling, divide by 8
		wr(CTRL_OFS, 32'h0);
		wr(CTRL_OFS, 32'h0);
		wr(CTRL_OFS, 32'h80a7);
		n = res_cnt;
		wr(CTRL_OFS, 32'h84a7);
		wait_res(n + 4);
		chk(last_data, {6'h0, 10'h2a5}, "right justified");
		chk(first_odd, 1'b0, "even input first");
		chk(last_gap, 8, "tick period");
		chk(irq_res, n + 2, "irq after first conversion");
		chk(shr_lag, 8, "shared sampled at second conversion");
		wr(STAT_OFS, 32'h0);
		$display("test integer format done");
		// external triggers on pairs 0 and 5: off, idle-stopped, then running
		wr(TRIG_OFS, 32'h3);
		wr(12'(TRIG_OFS + 20), 32'h3);
		wr(CTRL_OFS, 32'h0);
		n = res_cnt;
		pulse(6'h21);
		repeat (40) @(posedge pclk);
		chk(res_cnt, n, "module off");
		@(posedge pclk);
		device_idle <= 1'b1;
		wr(CTRL_OFS, 32'ha060); // sequential sampling, odd first
		pulse(6'h21);
		repeat (40) @(posedge pclk);
		chk(res_cnt, n, "stopped in idle");
		@(posedge pclk);
		device_idle <= 1'b0;
		pulse(6'h21);
		wait_res(n + 4);
		repeat (40) @(posedge pclk);
		rc(STAT_OFS, 32'h21);
		chk(shr_lag, 0, "shared sampled at first conversion");
		chk(conv_pair, 3'd5, "last pair converted");
		rc(BASE_OFS, 32'h0100);
		wr(STAT_OFS, 32'h20);
		rc(BASE_OFS, 32'h0114);
		$display("test external triggers done");
		give_verdict;
	end
endmodule
